// *** dv/rss_board_drv.sv ***
// Board-side open-drain drivers sharing the reset line
`timescale 1ns/1ps
module rss_board_drv (
  input  wire logic sys_clk,
  input  wire logic dev_oe,
  input  wire logic pullup_en,
  input  wire logic ext_low,
  output logic      pin_level
);
  logic last_r = 1'h1;
  always_comb pin_level = (dev_oe | ext_low) ? 1'h0 : (pullup_en ? 1'h1 : ~last_r);
  always_ff @(posedge sys_clk) last_r <= pin_level;
endmodule : rss_board_drv

// *** dv/test_rss_reset_sequencer.sv ***
// Self-checking bench for the reset source sequencer
`timescale 1ns/1ps
module test_rss_reset_sequencer;
  localparam int POR = 20;
  logic sys_clk = 0, rst_n = 0, power_on = 0, watchdog_timeout = 0, stop_mode = 0;
  logic stop_wake_recovery = 0, low_voltage_detect = 0, brownout_threshold = 0;
  logic ext_low = 0, recovery_delay_select = 1, clk_en = 1, port_dir_we = 0;
  logic [1:0]  wdt_select = 2'h0;
  logic        sys_reset_r, reset_pin_oe, reset_pullup_en, stop_recovered_r, pin_level;
  logic [7:0]  port_dir_input_r, port_dir_wdata = 8'h00;
  logic [24:0] wdt_timeout_cycles_r;
  int          fails = 0, total_checks = 0;

  rss_reset_sequencer #(.POR_CYC(POR), .WD0_CYC(8), .WD1_CYC(16), .WD2_CYC(32), .WD3_CYC(64))
    i_rss_reset_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .power_on(power_on), .watchdog_timeout(watchdog_timeout), .stop_mode(stop_mode),
    .stop_wake_recovery(stop_wake_recovery), .low_voltage_detect(low_voltage_detect),
    .brownout_threshold(brownout_threshold), .reset_pin_in(pin_level),
    .recovery_delay_select(recovery_delay_select), .wdt_select(wdt_select),
    .port_dir_we(port_dir_we), .port_dir_wdata(port_dir_wdata),
    .sys_reset_r(sys_reset_r), .reset_pin_out(), .reset_pin_oe(reset_pin_oe),
    .reset_pullup_en(reset_pullup_en), .port_dir_input_r(port_dir_input_r),
    .wdt_timeout_cycles_r(wdt_timeout_cycles_r), .stop_recovered_r(stop_recovered_r));
  rss_board_drv i_rss_board_drv (.sys_clk(sys_clk), .dev_oe(reset_pin_oe),
    .pullup_en(reset_pullup_en), .ext_low(ext_low), .pin_level(pin_level));

  initial forever #2 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic wait_rel(output int n);
    n = 0;
    while (sys_reset_r !== 1'h0 && n < 500) begin
      cyc(1);
      n++;
    end
  endtask : wait_rel
  task automatic pulse(ref logic src);
    src = 1;
    cyc(1);
    src = 0;
  endtask : pulse
  task automatic wr_dir(input logic [7:0] v);
    port_dir_we = 1;
    port_dir_wdata = v;
    cyc(1);
    port_dir_we = 0;
    chk("dir write", port_dir_input_r, v);
  endtask : wr_dir

  task automatic t_freeze();
    clk_en = 0;
    wdt_select = 2'h0;
    pulse(power_on);
    cyc(1);
    chk("frozen reset", sys_reset_r, 1'h0);
    chk("frozen oe", reset_pin_oe, 1'h0);
    chk("frozen wdt", wdt_timeout_cycles_r, 32'h40);
    clk_en = 1;
    cyc(2);
    chk("thawed wdt", wdt_timeout_cycles_r, 32'h8);
    chk("thawed reset", sys_reset_r, 1'h0);
    $display("test clock enable done");
  endtask : t_freeze

  task automatic t_wdt();
    int n;
    for (int bo = 0; bo < 2; bo++) begin
      brownout_threshold = bo[0];
      pulse(watchdog_timeout);
      chk("wd reset", sys_reset_r, 1'h1);
      chk("wd oe", reset_pin_oe, !bo[0]);
      chk("wd pin", pin_level, bo[0]);
      wait_rel(n);
      brownout_threshold = 0;
      cyc(2);
    end
    for (int s = 0; s < 4; s++) begin
      wdt_select = s[1:0];
      cyc(2);
      chk("wdt cycles", wdt_timeout_cycles_r, 32'h8 << s);
    end
    $display("test watchdog done");
  endtask : t_wdt

  task automatic t_ext();
    int n;
    ext_low = 1;
    cyc(2);
    ext_low = 0;
    chk("ext reset", sys_reset_r, 1'h1);
    chk("ext no drive", reset_pin_oe, 1'h0);
    wait_rel(n);
    pulse(low_voltage_detect);
    chk("lvd reset", sys_reset_r, 1'h1);
    wait_rel(n);
    stop_mode = 1;
    ext_low = 1;
    cyc(4);
    chk("stop ignores pin", sys_reset_r, 1'h0);
    ext_low = 0;
    stop_mode = 0;
    cyc(2);
    $display("test external done");
  endtask : t_ext

  task automatic t_wake();
    int n = 0;
    wr_dir(8'h00);
    stop_mode = 1;
    recovery_delay_select = 0;
    stop_wake_recovery = 1;
    for (int i = 1; i <= 8; i++) begin
      cyc(1);
      if (sys_reset_r === 1'h1 && n == 0) n = i;
    end
    chk("fast wake at", n >= 5 && n <= 7, 1'h1);
    stop_wake_recovery = 0;
    stop_mode = 0;
    cyc(3);
    chk("fast wake end", sys_reset_r, 1'h0);
    chk("wake flag", stop_recovered_r, 1'h1);
    chk("wake port", port_dir_input_r, 8'hFF);
    recovery_delay_select = 1;
    stop_mode = 1;
    stop_wake_recovery = 1;
    cyc(6);
    stop_wake_recovery = 0;
    stop_mode = 0;
    wait_rel(n);
    chk("slow wake len", n >= POR - 2 && n <= POR + 8, 1'h1);
    $display("test wake done");
  endtask : t_wake

  task automatic t_por();
    int n;
    wr_dir(8'h0F);
    pulse(power_on);
    chk("por oe", reset_pin_oe, 1'h1);
    chk("por pullup", reset_pullup_en, 1'h0);
    wait_rel(n);
    chk("por length", n >= POR - 3 && n <= POR + 3, 1'h1);
    chk("oe off", reset_pin_oe, 1'h0);
    chk("pullup on", reset_pullup_en, 1'h1);
    chk("cold flag", stop_recovered_r, 1'h0);
    chk("por port", port_dir_input_r, 8'hFF);
    $display("test power on done");
  endtask : t_por

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial begin
    #40000;
    fails++;
    test_done();
  end

  initial begin
    cyc(4);
    chk("rst port", port_dir_input_r, 8'hFF);
    chk("rst wdt", wdt_timeout_cycles_r, 32'h8);
    rst_n = 1;
    cyc(2);
    t_wdt();
    t_freeze();
    t_ext();
    t_wake();
    t_por();
    test_done();
  end
endmodule : test_rss_reset_sequencer

// *** src/rss_delay_counter.sv ***
// Loadable down counter that flags expiry
`timescale 1ns/1ps
module rss_delay_counter #(
  parameter int W = 25
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy
);
  logic [W-1:0] count_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (clk_en) begin
      if (load) begin
        count_r <= load_val;
      end else if (count_r != '0) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (clk_en) begin
      busy <= load || (count_r > {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule : rss_delay_counter

// *** src/rss_pkg.sv ***
// Package with constants for the reset source sequencer
package rss_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int POR_MIN_US       = 2500;
  localparam int POR_MAX_US       = 10000;
  // Cycles for the minimum power-on delay, rounded up
  localparam int POR_CYCLES       = (POR_MIN_US * 1000 + CLK_PERIOD_PS / 1000 - 1)
                                  / (CLK_PERIOD_PS / 1000);
  localparam int WDT_SEL0_MS      = 5;
  localparam int WDT_SEL1_MS      = 10;
  localparam int WDT_SEL2_MS      = 20;
  localparam int WDT_SEL3_MS      = 80;
  localparam int WDT_SEL0_CYCLES  = (WDT_SEL0_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int WDT_SEL1_CYCLES  = (WDT_SEL1_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int WDT_SEL2_CYCLES  = (WDT_SEL2_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int WDT_SEL3_CYCLES  = (WDT_SEL3_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int FAST_WAKE_CYCLES = 5;
  localparam int CNT_W            = 25;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_DIR_INPUT = 8'hFF;
  localparam logic [1:0] WDT_SEL_RST    = 2'h0;
endpackage : rss_pkg

// *** src/rss_reset_sequencer.sv ***
// Reset source merging, pin drive and power-on delay sequencing
`timescale 1ns/1ps
module rss_reset_sequencer #(
  parameter int POR_CYC = rss_pkg::POR_CYCLES,
  parameter int WD0_CYC = rss_pkg::WDT_SEL0_CYCLES,
  parameter int WD1_CYC = rss_pkg::WDT_SEL1_CYCLES,
  parameter int WD2_CYC = rss_pkg::WDT_SEL2_CYCLES,
  parameter int WD3_CYC = rss_pkg::WDT_SEL3_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       power_on,
  input  wire logic       watchdog_timeout,
  input  wire logic       stop_mode,
  input  wire logic       stop_wake_recovery,
  input  wire logic       low_voltage_detect,
  input  wire logic       brownout_threshold,
  input  wire logic       reset_pin_in,
  input  wire logic       recovery_delay_select,
  input  wire logic [1:0] wdt_select,
  input  wire logic       port_dir_we,
  input  wire logic [7:0] port_dir_wdata,
  output logic            sys_reset_r,
  output logic            reset_pin_out,
  output logic            reset_pin_oe,
  output logic            reset_pullup_en,
  output logic [7:0]      port_dir_input_r,
  output logic [24:0]     wdt_timeout_cycles_r,
  output logic            stop_recovered_r
);
  // ---------------------------------------------------------------
  // Source qualification
  // ---------------------------------------------------------------
  logic [rss_pkg::CNT_W-1:0] load_val;
  logic                      delay_busy;
  logic                      load;
  logic                      delay_load;
  logic                      drive_src;
  logic                      ext_src;
  logic                      wake_src;
  logic                      pin_drive_r;
  logic [2:0]                wake_cnt_r;
  logic                      fast_ok;

  function automatic logic [24:0] wdt_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: wdt_cycles = 25'(WD0_CYC);
      2'h1: wdt_cycles = 25'(WD1_CYC);
      2'h2: wdt_cycles = 25'(WD2_CYC);
      2'h3: wdt_cycles = 25'(WD3_CYC);
    endcase
  endfunction : wdt_cycles

  assign drive_src = power_on || watchdog_timeout;
  assign ext_src   = !reset_pin_in && !stop_mode && !pin_drive_r;
  assign wake_src  = stop_mode && stop_wake_recovery;
  assign fast_ok   = wake_cnt_r >= 3'(rss_pkg::FAST_WAKE_CYCLES - 1);
  assign load      = drive_src || ext_src || low_voltage_detect
                  || (wake_src && (recovery_delay_select || fast_ok));
  assign load_val  = rss_pkg::CNT_W'(POR_CYC);
  // delay restarts on every slow source
  assign delay_load = drive_src || ext_src || low_voltage_detect
                   || (wake_src && recovery_delay_select);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_cnt_r <= 3'h0;
    end else if (clk_en) begin
      if (!wake_src) begin
        wake_cnt_r <= 3'h0;
      end else if (!fast_ok) begin
        wake_cnt_r <= wake_cnt_r + 3'h1;
      end
    end
  end

  rss_delay_counter #(
    .W (rss_pkg::CNT_W)
  ) u_delay (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .load     (delay_load),
    .load_val (load_val),
    .busy     (delay_busy)
  );

  // ---------------------------------------------------------------
  // Internal reset and pin drive
  // ---------------------------------------------------------------
  // hold until delay expires
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sys_reset_r <= 1'b1;
    end else if (clk_en) begin
      sys_reset_r <= load || delay_busy;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_drive_r <= 1'b0;
    end else if (clk_en) begin
      if (drive_src) begin
        pin_drive_r <= 1'b1;
      end else if (!delay_busy) begin
        pin_drive_r <= 1'b0;
      end
    end
  end

  // drive low for delay on power-on or watchdog only; never under brownout
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reset_pin_oe <= 1'b0;
    end else if (clk_en) begin
      reset_pin_oe <= (drive_src || (pin_drive_r && delay_busy)) && !brownout_threshold;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reset_pin_out <= 1'b0;
    end else if (clk_en) begin
      reset_pin_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reset_pullup_en <= 1'b1;
    end else if (clk_en) begin
      reset_pullup_en <= !((drive_src || (pin_drive_r && delay_busy)) && !brownout_threshold);
    end
  end

  // ---------------------------------------------------------------
  // Port direction, watchdog select and warm start
  // ---------------------------------------------------------------
  // port to input after reset or wake
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      port_dir_input_r <= rss_pkg::PORT_DIR_INPUT;
    end else if (clk_en) begin
      // Forced input wins over a write in the same cycle
      if (load) begin
        port_dir_input_r <= rss_pkg::PORT_DIR_INPUT;
      end else if (port_dir_we) begin
        port_dir_input_r <= port_dir_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wdt_timeout_cycles_r <= wdt_cycles(rss_pkg::WDT_SEL_RST);
    end else if (clk_en) begin
      wdt_timeout_cycles_r <= wdt_cycles(wdt_select);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_recovered_r <= 1'b0;
    end else if (clk_en) begin
      if (wake_src && (recovery_delay_select || fast_ok)) begin
        stop_recovered_r <= 1'b1;
      end else if (drive_src || ext_src || low_voltage_detect) begin
        stop_recovered_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_src_resets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && low_voltage_detect) |=> sys_reset_r)
    else $error("reset source did not assert reset");
  a_pin_driven: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && power_on && !brownout_threshold) |=> reset_pin_oe)
    else $error("pin not driven on power-on");
  a_pullup_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_pin_oe |-> !reset_pullup_en)
    else $error("pull-up on while driving");
  a_no_brownout: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && brownout_threshold) |=> !reset_pin_oe)
    else $error("pin driven under brownout");
  a_pin_no_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && stop_mode && !stop_wake_recovery && !power_on && !watchdog_timeout
     && !low_voltage_detect && !delay_busy && !reset_pin_in) |=> !sys_reset_r)
    else $error("external pin woke from stop");
  a_wdt_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wdt_select == 2'h3) |=> wdt_timeout_cycles_r == 25'(WD3_CYC))
    else $error("watchdog select wrong");
  a_port_input: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && load) |=> port_dir_input_r == rss_pkg::PORT_DIR_INPUT)
    else $error("port not input after reset");
  a_fast_short: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && $rose(wake_src) && !recovery_delay_select && !drive_src
     && !low_voltage_detect) |-> !load)
    else $error("fast wake accepted too early");
  a_release_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && delay_busy) |=> sys_reset_r)
    else $error("reset released before delay ended");
  a_wake_port: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && wake_src && (recovery_delay_select || fast_ok))
    |=> (port_dir_input_r == rss_pkg::PORT_DIR_INPUT) && stop_recovered_r)
    else $error("port not input after stop recovery");
  sequence s_wake_held;
    (clk_en && wake_src && !recovery_delay_select) [*5];
  endsequence
  a_fast_accept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_wake_held |=> sys_reset_r && stop_recovered_r)
    else $error("fast wake not accepted after five cycles");
  a_hold_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!clk_en) |=> $stable(sys_reset_r) && $stable(reset_pin_oe)
                 && $stable(port_dir_input_r) && $stable(wdt_timeout_cycles_r))
    else $error("state moved while clock enable low");
endmodule : rss_reset_sequencer
